// ### core/ocmp_map.svh
`ifndef OCMP_MAP_SVH
`define OCMP_MAP_SVH
// Register byte addresses on the AXI4-Lite bus.
`define ADDR_CTRL_ONE 8'h00
`define ADDR_CTRL_TWO 8'h04
`define ADDR_PRIMARY 8'h08
`define ADDR_SECONDARY 8'h0c
`define ADDR_TIMER 8'h10
// Control one field positions.
`define C1_IDLE_STOP 13
`define C1_CLKSEL_HI 12
`define C1_CLKSEL_LO 10
`define C1_FAULT_EN 7
`define C1_FAULT_STAT 4
`define C1_TRIG_CLR_MODE 3
`define C1_MODE_HI 2
`define C1_MODE_LO 0
`define C1_WMASK 16'h3c9f
// Control two field positions.
`define C2_FAULT_HOLD 15
`define C2_FAULT_LEVEL 14
`define C2_FAULT_TRIS 13
`define C2_INVERT 12
`define C2_CASCADE 8
`define C2_TRIG_SEL 7
`define C2_TRIG_STAT 6
`define C2_TRISTATE 5
`define C2_SRC_HI 4
`define C2_SRC_LO 0
`define C2_WMASK 16'hf1ff
// Reset values.
`define C1_RESET 16'h0000
`define C2_RESET 16'h000c
// Source codes.
`define SRC_NONE 5'h00
`define SRC_OWN_SEC 5'h1f
`define SRC_RESERVED_A 5'h1c
`define SRC_TRIGGEN 5'h0a
`define SRC_RESERVED_B 5'h09
// Clock select codes.
`define CLK_PERIPH 3'h7
`define CLK_TIMER_ONE 3'h4
`endif

// ### core/ocmp_pkg.sv
package ocmp_pkg;
	// Output compare modes.
	typedef enum logic [2:0] {
		MODE_OFF = 3'h0,
		MODE_SINGLE_HIGH = 3'h1,
		MODE_SINGLE_LOW = 3'h2,
		MODE_TOGGLE = 3'h3,
		MODE_DOUBLE_SHOT = 3'h4,
		MODE_DOUBLE_CONT = 3'h5,
		MODE_PWM_EDGE = 3'h6,
		MODE_PWM_CENTRE = 3'h7
	} mode_e;
	typedef logic [15:0] word_t;
endpackage : ocmp_pkg

// ### core/ocmp_sync2.sv
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for a bundle of asynchronous levels.
module ocmp_sync2 #(
	parameter int WIDTH = 1
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic sys_rst,
	// Levels.
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage;

	// Only the second stage is visible, to keep metastability contained.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			stage <= '0;
			sync_out <= '0;
		end else begin
			stage <= async_in;
			sync_out <= stage;
		end
	end
endmodule : ocmp_sync2
`default_nettype wire

// ### core/ocmp_source_mux.sv
`timescale 1ns/1ps
`default_nettype none
`include "ocmp_map.svh"
// Picks the synchronization or trigger event named by the source field.
module ocmp_source_mux #(
	parameter int CHANNEL = 1
) (
	// Selection.
	input wire logic [4:0] sel,
	// Candidate events, all in the clk domain.
	input wire logic own_secondary_match,
	input wire logic [2:1] ext_pin,
	input wire logic [4:1] comparator,
	input wire logic [4:1] capture_irq,
	input wire logic [4:1] capture_evt,
	input wire logic [5:1] general_timer,
	input wire logic [3:0] trigger_generator,
	input wire logic [4:1] compare_chan,
	// Chosen event.
	output logic event_out
);
	// Reserved and zero codes give no event.
	always_comb begin
		event_out = 1'b0;
		if (sel == `SRC_OWN_SEC)
			event_out = own_secondary_match; // RL13
		else if (sel == 5'h1e)
			event_out = ext_pin[2]; // RL14
		else if (sel == 5'h1d)
			event_out = ext_pin[1]; // RL14
		else if (sel >= 5'h18 && sel <= 5'h1b)
			event_out = comparator[3'(sel[1:0]) + 3'h1]; // RL14
		else if (sel >= 5'h10 && sel <= 5'h13)
			event_out = capture_irq[3'(sel[1:0]) + 3'h1]; // RL15
		else if (sel >= 5'h0b && sel <= 5'h0f)
			event_out = general_timer[3'(sel - 5'h0a)]; // RL16
		else if (sel == `SRC_TRIGGEN)
			event_out = trigger_generator[2'(CHANNEL - 1)]; // RL17
		else if (sel >= 5'h05 && sel <= 5'h08)
			event_out = capture_evt[3'(sel - 5'h04)]; // RL15
		else if (sel >= 5'h01 && sel <= 5'h04)
			event_out = compare_chan[3'(sel)]; // RL18
	end
endmodule : ocmp_source_mux
`default_nettype wire

// ### core/output_compare_channel.sv
// Contract
// (RL1) Idle-stop bit set halts channel during CPU idle; clear keeps it running.
// (RL2) Fault A status flag set by hardware on fault pin; software reads/writes.
// (RL3) Compare values double-buffered only in PWM modes, else immediate.
// (RL4) Mode 111: high at primary match, low at secondary match.
// (RL5) Mode 110: high at timer zero, low at primary match.
// (RL6) Mode 101: start low, toggle on alternate primary/secondary matches.
// (RL7) Mode 100: start low, toggle on primary and secondary once.
// (RL8) Mode 011: toggle on every primary match.
// (RL9) Mode 010: start high, go low at primary match.
// (RL10) Mode 001: start low, go high at primary match.
// (RL11) Mode 000 disables the channel.
// (RL12) Fault hold mode keeps fault until software clear and new period.
// (RL13) Source 11111 uses own secondary match as sync.
// (RL14) Codes 11110/11101 pins 2/1; 11011-11000 comparators 4-1.
// (RL15) 10011-10000 capture interrupts; 01000-00101 capture events 4-1.
// (RL16) 01111-01011 general timers 5-1; 01100 is reset default.
// (RL17) 01010 selects trigger generator output channel minus one.
// (RL18) 00100-00001 select compare channels 4-1.
// (RL19) 00000 gives no sync and no trigger.
// (RL20) Software never picks this channel as its own source.
// (RL21) Turning channel off emits a trigger-out pulse.
// (RL22) Software deselects a source channel before disabling it.
// (RL23) Channel can flag compare match events.
// (RL24) Three-bit clock select; 111 peripheral clock, 110/101 reserved.
// (RL25) Trigger mode: source sets status; timer held clear while status clear.
`timescale 1ns/1ps
`default_nettype none
`include "ocmp_map.svh"
module output_compare_channel #(
	parameter int CHANNEL = 1,
	parameter int TW = 16
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic sys_rst,
	// AXI4-Lite write address and data.
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read.
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// System state and clock ticks, same domain.
	input wire logic cpu_idle,
	input wire logic peripheral_clock_tick,
	input wire logic [5:1] timer_clock_tick,
	// Asynchronous pins.
	input wire logic fault_a_input_pin,
	input wire logic [2:1] ext_pin,
	// Sync and trigger sources, same domain.
	input wire logic [4:1] comparator,
	input wire logic [4:1] capture_irq,
	input wire logic [4:1] capture_evt,
	input wire logic [5:1] general_timer,
	input wire logic [3:0] trigger_generator,
	input wire logic [4:1] compare_chan,
	// Compare pin and events.
	output logic compare_out,
	output logic compare_out_en,
	output logic match_event,
	output logic trigger_out
);
	ocmp_pkg::word_t ctrl_one;
	ocmp_pkg::word_t ctrl_two;
	logic [TW-1:0] pri_reg, sec_reg, pri_act, sec_act, timer;
	logic pin_level, shot_done, fault_latched, fault_s;
	logic [2:1] ext_s;
	logic src_event, tick, run, pri_hit, sec_hit, zero_hit, period_start;
	logic pwm_mode, was_on;
	ocmp_pkg::mode_e mode, last_mode;
	// Register fields.
	assign mode = ocmp_pkg::mode_e'(ctrl_one[`C1_MODE_HI:`C1_MODE_LO]);
	assign pwm_mode = mode == ocmp_pkg::MODE_PWM_EDGE || mode == ocmp_pkg::MODE_PWM_CENTRE;
	ocmp_sync2 #(.WIDTH(3)) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.async_in({fault_a_input_pin, ext_pin}),
		.sync_out({fault_s, ext_s})
	);
	ocmp_source_mux #(.CHANNEL(CHANNEL)) u_mux (
		.sel(ctrl_two[`C2_SRC_HI:`C2_SRC_LO]),
		.own_secondary_match(sec_hit),
		.ext_pin(ext_s),
		.comparator(comparator),
		.capture_irq(capture_irq),
		.capture_evt(capture_evt),
		.general_timer(general_timer),
		.trigger_generator(trigger_generator),
		.compare_chan(compare_chan),
		.event_out(src_event)
	);
	// Clock select; reserved codes give no tick, so the timer stands.
	always_comb begin
		tick = 1'b0;
		case (ctrl_one[`C1_CLKSEL_HI:`C1_CLKSEL_LO])
			`CLK_PERIPH: tick = peripheral_clock_tick; // RL24
			`CLK_TIMER_ONE: tick = timer_clock_tick[1]; // RL24
			3'h3: tick = timer_clock_tick[5]; // RL24
			3'h2: tick = timer_clock_tick[4];
			3'h1: tick = timer_clock_tick[2];
			3'h0: tick = timer_clock_tick[3];
			default: tick = 1'b0;
		endcase
	end
	// Channel advances only when on, not idle-stopped and not awaiting trigger.
	assign run = mode != ocmp_pkg::MODE_OFF // RL11
		&& !(cpu_idle && ctrl_one[`C1_IDLE_STOP]) // RL1
		&& !(ctrl_two[`C2_TRIG_SEL] && !ctrl_two[`C2_TRIG_STAT]); // RL25
	assign pri_hit = run && tick && timer == pri_act;
	assign sec_hit = run && tick && timer == sec_act;
	assign zero_hit = run && tick && timer == '0;
	assign period_start = zero_hit;
	assign match_event = pri_hit || sec_hit; // RL23
	// AXI handshake state.
	logic aw_full, w_full;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	assign s_axi_awready = !aw_full && !s_axi_bvalid;
	assign s_axi_wready = !w_full && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign do_write = aw_full && w_full && !s_axi_bvalid;
	// Address and data are captured independently, in either order.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_full <= 1'b0;
				w_full <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= decode_ok(aw_addr) ? 2'h0 : 2'h2;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	// Unmapped addresses answer with a slave error.
	function automatic logic decode_ok(input logic [7:0] a);
		decode_ok = a == `ADDR_CTRL_ONE || a == `ADDR_CTRL_TWO || a == `ADDR_PRIMARY
			|| a == `ADDR_SECONDARY || a == `ADDR_TIMER;
	endfunction : decode_ok
	// Byte-lane merge of the low half word.
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction : merge
	// Control one; hardware fault set wins over a software clear.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_one <= `C1_RESET;
		end else begin
			if (do_write && aw_addr == `ADDR_CTRL_ONE)
				ctrl_one <= merge(ctrl_one, w_data, w_strb) & `C1_WMASK;
			if (ctrl_one[`C1_FAULT_EN] && fault_s)
				ctrl_one[`C1_FAULT_STAT] <= 1'b1; // RL2
		end
	end
	// Control two; trigger status set by the source, cleared by match if chosen.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_two <= `C2_RESET; // RL16
		end else begin
			if (do_write && aw_addr == `ADDR_CTRL_TWO)
				ctrl_two <= merge(ctrl_two, w_data, w_strb) & `C2_WMASK;
			else if (ctrl_one[`C1_TRIG_CLR_MODE] && sec_hit)
				ctrl_two[`C2_TRIG_STAT] <= 1'b0;
			if (ctrl_two[`C2_TRIG_SEL] && src_event)
				ctrl_two[`C2_TRIG_STAT] <= 1'b1; // RL25
		end
	end
	// Compare values: written shadows, loaded to active at period start in PWM.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pri_reg <= '0;
			sec_reg <= '0;
			pri_act <= '0;
			sec_act <= '0;
		end else begin
			if (do_write && aw_addr == `ADDR_PRIMARY)
				pri_reg <= TW'(merge(16'(pri_reg), w_data, w_strb));
			if (do_write && aw_addr == `ADDR_SECONDARY)
				sec_reg <= TW'(merge(16'(sec_reg), w_data, w_strb));
			if (!pwm_mode || period_start || mode == ocmp_pkg::MODE_OFF) begin
				pri_act <= pri_reg; // RL3
				sec_act <= sec_reg; // RL3
			end
		end
	end
	// Dedicated timer; cleared by sync events and while awaiting trigger.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			timer <= '0;
		end else if (do_write && aw_addr == `ADDR_TIMER) begin
			timer <= TW'(merge(16'(timer), w_data, w_strb));
		end else if (mode == ocmp_pkg::MODE_OFF) begin
			timer <= '0;
		end else if (ctrl_two[`C2_TRIG_SEL] && !ctrl_two[`C2_TRIG_STAT]) begin
			timer <= '0; // RL25
		end else if (!ctrl_two[`C2_TRIG_SEL] && src_event
			&& ctrl_two[`C2_SRC_HI:`C2_SRC_LO] != `SRC_NONE) begin
			timer <= '0; // RL19
		end else if (run && tick) begin
			timer <= timer + 1'b1;
		end
	end
	// Pin state per mode; a mode change reinitialises the pin.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_level <= 1'b0;
			shot_done <= 1'b0;
			last_mode <= ocmp_pkg::MODE_OFF;
		end else begin
			last_mode <= mode;
			if (mode != last_mode) begin
				pin_level <= mode == ocmp_pkg::MODE_SINGLE_LOW; // RL9
				shot_done <= 1'b0;
			end else begin
				case (mode)
					ocmp_pkg::MODE_OFF: pin_level <= 1'b0; // RL11
					ocmp_pkg::MODE_SINGLE_HIGH: if (pri_hit) pin_level <= 1'b1; // RL10
					ocmp_pkg::MODE_SINGLE_LOW: if (pri_hit) pin_level <= 1'b0; // RL9
					ocmp_pkg::MODE_TOGGLE: if (pri_hit) pin_level <= !pin_level; // RL8
					ocmp_pkg::MODE_DOUBLE_SHOT: begin
						if (pri_hit && !shot_done)
							pin_level <= 1'b1; // RL7
						if (sec_hit && pin_level) begin
							pin_level <= 1'b0; // RL7
							shot_done <= 1'b1;
						end
					end
					ocmp_pkg::MODE_DOUBLE_CONT: begin
						if (pri_hit)
							pin_level <= 1'b1; // RL6
						if (sec_hit)
							pin_level <= 1'b0; // RL6
					end
					ocmp_pkg::MODE_PWM_EDGE: begin
						if (zero_hit)
							pin_level <= 1'b1; // RL5
						if (pri_hit)
							pin_level <= 1'b0; // RL5
					end
					ocmp_pkg::MODE_PWM_CENTRE: begin
						if (pri_hit)
							pin_level <= 1'b1; // RL4
						if (sec_hit)
							pin_level <= 1'b0; // RL4
					end
					default: pin_level <= 1'b0;
				endcase
			end
		end
	end
	// Fault latch; in hold mode it waits for software clear and a new period.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			fault_latched <= 1'b0;
		end else if (ctrl_one[`C1_FAULT_EN] && fault_s) begin
			fault_latched <= 1'b1;
		end else if (!ctrl_one[`C1_FAULT_STAT]
			&& (!ctrl_two[`C2_FAULT_HOLD] || period_start)) begin
			fault_latched <= 1'b0; // RL12
		end
	end
	// Turn-off pulse toward channels using this one as source.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			was_on <= 1'b0;
			trigger_out <= 1'b0;
		end else begin
			was_on <= mode != ocmp_pkg::MODE_OFF;
			trigger_out <= was_on && mode == ocmp_pkg::MODE_OFF; // RL21
		end
	end
	// Pin drive; fault overrides level or tri-states, then inversion applies.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			compare_out <= 1'b0;
			compare_out_en <= 1'b0;
		end else begin
			compare_out <= (fault_latched ? ctrl_two[`C2_FAULT_LEVEL] : pin_level)
				^ ctrl_two[`C2_INVERT];
			compare_out_en <= !ctrl_two[`C2_TRISTATE]
				&& !(fault_latched && ctrl_two[`C2_FAULT_TRIS]);
		end
	end
	// Read path, one cycle after the address is taken.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= decode_ok(s_axi_araddr) ? 2'h0 : 2'h2;
			case (s_axi_araddr)
				`ADDR_CTRL_ONE: s_axi_rdata <= {16'h0, ctrl_one};
				`ADDR_CTRL_TWO: s_axi_rdata <= {16'h0, ctrl_two};
				`ADDR_PRIMARY: s_axi_rdata <= 32'(pri_reg);
				`ADDR_SECONDARY: s_axi_rdata <= 32'(sec_reg);
				`ADDR_TIMER: s_axi_rdata <= 32'(timer);
				default: s_axi_rdata <= 32'h0;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
	chk_off_quiet: assert property (@(posedge clk) disable iff (sys_rst) // RL11
		mode == ocmp_pkg::MODE_OFF |-> !match_event)
		else $error("match while disabled");
	chk_idle_halt: assert property (@(posedge clk) disable iff (sys_rst) // RL1
		cpu_idle && ctrl_one[`C1_IDLE_STOP] && mode != ocmp_pkg::MODE_OFF && !do_write
		&& !src_event && !ctrl_two[`C2_TRIG_SEL] |=> $stable(timer))
		else $error("ran during idle stop");
	chk_trig_hold: assert property (@(posedge clk) disable iff (sys_rst) // RL25
		ctrl_two[`C2_TRIG_SEL] && !ctrl_two[`C2_TRIG_STAT] && !do_write |=> timer == '0)
		else $error("timer not held clear");
	chk_edge_low: assert property (@(posedge clk) disable iff (sys_rst) // RL5
		mode == ocmp_pkg::MODE_PWM_EDGE && $stable(mode) && pri_hit |=> !pin_level)
		else $error("edge pwm not low at match");
	chk_centre_high: assert property (@(posedge clk) disable iff (sys_rst) // RL4
		mode == ocmp_pkg::MODE_PWM_CENTRE && $stable(mode) && pri_hit && !sec_hit
		|=> pin_level)
		else $error("centre pwm not high at match");
	chk_toggle_flip: assert property (@(posedge clk) disable iff (sys_rst) // RL8
		mode == ocmp_pkg::MODE_TOGGLE && $stable(mode) && pri_hit
		|=> pin_level != $past(pin_level))
		else $error("toggle missed");
	chk_single_high: assert property (@(posedge clk) disable iff (sys_rst) // RL10
		mode == ocmp_pkg::MODE_SINGLE_HIGH && $stable(mode) && pri_hit |=> pin_level)
		else $error("single high missed");
	chk_off_pulse: assert property (@(posedge clk) disable iff (sys_rst) // RL21
		$fell(mode != ocmp_pkg::MODE_OFF) |=> trigger_out ##1 !trigger_out)
		else $error("no turn off pulse");
	chk_fault_flag: assert property (@(posedge clk) disable iff (sys_rst) // RL2
		ctrl_one[`C1_FAULT_EN] && fault_s |=> ctrl_one[`C1_FAULT_STAT])
		else $error("fault flag not set");
endmodule : output_compare_channel
`default_nettype wire

// ### tb/ocmp_load.sv
`timescale 1ns/1ps
`default_nettype none
// Load on the compare pin; it counts rising edges so the bench can measure pulse trains.
module ocmp_load (
	// Clock and reset.
	input wire logic clk,
	input wire logic sys_rst,
	// Pin driven by the channel.
	input wire logic compare_out,
	input wire logic compare_out_en,
	// What the load sees.
	output logic level,
	output logic [15:0] rises
);
	logic prev;
	// A pull-down holds the pin low while the channel lets it float.
	assign level = compare_out_en ? compare_out : 1'b0;
	// Edges are counted, never levels, so a window difference gives the pulse count.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			prev <= 1'b0;
			rises <= 16'h0000;
		end else begin
			prev <= level;
			if (level && !prev) begin
				rises <= rises + 16'h0001;
			end
		end
	end
endmodule : ocmp_load
`default_nettype wire

// ### tb/output_compare_channel_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ocmp_map.svh"
module output_compare_channel_tb;
	logic clk, sys_rst, awv, wv, arv, idle, flt;
	logic [7:0] awa, ara;
	logic [31:0] wd, rd;
	logic [1:0] rs, bresp, rresp;
	logic awr, wr, bv, arr, rv, cout, coen, mev, tout, lvl, brdy, rrdy;
	logic [31:0] rdata;
	logic [2:1] ext;
	logic [4:1] cmp, cirq, cevt, och;
	logic [5:1] gtm;
	logic [3:0] tgen;
	logic [4:0] sc;
	logic [15:0] rises, r0;
	int err_count, checks, trig_n, match_n, t0, m0;
	int lo [1:7] = '{1, 0, 4, 1, 8, 8, 8};
	int hi [1:7] = '{1, 0, 6, 1, 11, 11, 11};
	int st [1:7] = '{0, 1, -1, 0, 0, -1, -1};
	int en [1:7] = '{1, 0, -1, 0, -1, -1, -1};
	logic [15:0] cfg [4] = '{16'h3c05, 16'h1c05, 16'h1805, 16'h1005};
	logic mv [4] = '{1'b0, 1'b1, 1'b0, 1'b1};

	output_compare_channel #(.CHANNEL(1), .TW(16)) DUT (
		.clk(clk), .sys_rst(sys_rst),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
		.s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brdy),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
		.cpu_idle(idle), .peripheral_clock_tick(1'b1), .timer_clock_tick(5'h1f),
		.fault_a_input_pin(flt), .ext_pin(ext), .comparator(cmp), .capture_irq(cirq),
		.capture_evt(cevt), .general_timer(gtm), .trigger_generator(tgen),
		.compare_chan(och), .compare_out(cout), .compare_out_en(coen),
		.match_event(mev), .trigger_out(tout)
	);
	ocmp_load LOAD (.clk(clk), .sys_rst(sys_rst), .compare_out(cout),
		.compare_out_en(coen), .level(lvl), .rises(rises));

	// Free-running bench clock at 20 MHz.
	always #25 clk = ~clk;

	// Event pulses are counted so windows can be compared by difference.
	always @(posedge clk) begin
		if (tout === 1'b1) trig_n <= trig_n + 1;
		if (mev === 1'b1) match_n <= match_n + 1;
	end

	task automatic end_of_test();
		if (err_count == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	// Ready is looked at mid-cycle, where it is settled, and the item moves at the next edge.
	task automatic axi_write(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
		logic pa, pw, ga, gw, b;
		awa <= a;
		wd <= {16'h0000, d};
		awv <= 1'b1;
		wv <= 1'b1;
		pa = 1'b1;
		pw = 1'b1;
		while (pa || pw) begin
			@(negedge clk);
			ga = pa && awr;
			gw = pw && wr;
			@(posedge clk);
			if (ga) begin
				awv <= 1'b0;
				pa = 1'b0;
			end
			if (gw) begin
				wv <= 1'b0;
				pw = 1'b0;
			end
		end
		// The response is accepted only once both items are in, and held until it is seen.
		brdy <= 1'b1;
		b = 1'b0;
		while (!b) begin
			@(negedge clk);
			b = bv;
			r = bresp;
			@(posedge clk);
		end
		brdy <= 1'b0;
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ok;
		ara <= a;
		arv <= 1'b1;
		ok = 1'b0;
		while (!ok) begin
			@(negedge clk);
			ok = arr;
			@(posedge clk);
		end
		arv <= 1'b0;
		rrdy <= 1'b1;
		ok = 1'b0;
		while (!ok) begin
			@(negedge clk);
			ok = rv;
			d = rdata;
			r = rresp;
			@(posedge clk);
		end
		rrdy <= 1'b0;
	endtask : axi_read

	// Drives the one source that a code names; code zero drives every source at once.
	task automatic src(input logic [4:0] c, input logic v);
		case (c) inside
			5'h00: {ext, cmp, cirq, cevt, gtm, tgen, och} <= {27{v}};
			[5'h1d:5'h1e]: ext[int'(c) - 28] <= v;
			[5'h18:5'h1b]: cmp[int'(c) - 23] <= v;
			[5'h10:5'h13]: cirq[int'(c) - 15] <= v;
			[5'h0b:5'h0f]: gtm[int'(c) - 10] <= v;
			5'h0a: tgen[0] <= v;
			[5'h05:5'h08]: cevt[int'(c) - 4] <= v;
			default: och[int'(c)] <= v;
		endcase
	endtask : src

	// Watchdog sized well beyond the expected run of some 5300 cycles.
	initial begin
		repeat (40000) @(posedge clk);
		err_count++;
		end_of_test();
	end

	initial begin
		clk = 1'b0;
		sys_rst = 1'b1;
		{awv, wv, arv, brdy, rrdy, idle, flt, awa, ara, wd} = '0;
		{ext, cmp, cirq, cevt, gtm, tgen, och} = '0;
		{err_count, checks, trig_n, match_n} = '0;
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		axi_read(`ADDR_CTRL_ONE, rd, rs);
		chk("ctrl_one_rst", rd, 32'h00000000);
		axi_read(`ADDR_CTRL_TWO, rd, rs);
		chk("ctrl_two_rst", rd, 32'h0000000c);
		axi_read(8'h14, rd, rs);
		chk("unmapped_rd", {rs, rd[29:0]}, 32'h80000000);
		axi_write(8'h14, 16'hffff, rs);
		chk("unmapped_wr", rs, 2'b10);
		axi_write(`ADDR_PRIMARY, 16'h0014, rs);
		axi_write(`ADDR_SECONDARY, 16'h0028, rs);
		// Every mode, each restarted from the disabled state with the period set by sync.
		for (int m = 1; m <= 8; m++) begin
			t0 = trig_n;
			axi_write(`ADDR_CTRL_TWO, 16'h0000, rs);
			axi_write(`ADDR_CTRL_ONE, 16'h1c00, rs);
			repeat (4) @(posedge clk);
			if (m > 1) chk("trig_out", trig_n - t0, 1);
			if (m == 8) break;
			axi_write(`ADDR_CTRL_TWO, 16'h001f, rs);
			axi_write(`ADDR_TIMER, 16'h0000, rs);
			axi_write(`ADDR_CTRL_ONE, 16'h1c00 | 16'(m), rs);
			repeat (4) @(posedge clk);
			if (st[m] >= 0) chk("start_lvl", lvl, st[m]);
			r0 = rises;
			m0 = match_n;
			repeat (400) @(posedge clk);
			chk("rises", (rises - r0 >= lo[m]) && (rises - r0 <= hi[m]), 1);
			if (en[m] >= 0) chk("end_lvl", lvl, en[m]);
			chk("match", match_n - m0 >= 8, 1);
		end
		r0 = rises;
		repeat (200) @(posedge clk);
		chk("off_rises", rises - r0, 0);
		chk("off_lvl", lvl, 0);
		// Idle stop and clock select; a stopped timer gives no pulses at all.
		axi_write(`ADDR_CTRL_TWO, 16'h001f, rs);
		idle <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			axi_write(`ADDR_CTRL_ONE, cfg[i], rs);
			r0 = rises;
			repeat (400) @(posedge clk);
			chk("runs", rises != r0, mv[i]);
		end
		idle <= 1'b0;
		axi_write(`ADDR_CTRL_ONE, 16'h1c80, rs);
		flt <= 1'b1;
		repeat (5) @(posedge clk);
		flt <= 1'b0;
		repeat (5) @(posedge clk);
		axi_read(`ADDR_CTRL_ONE, rd, rs);
		chk("fault_set", rd[4], 1);
		axi_write(`ADDR_CTRL_ONE, 16'h1c80, rs);
		axi_read(`ADDR_CTRL_ONE, rd, rs);
		chk("fault_clr", rd[4], 0);
		// Trigger operation: the timer waits for its source before it runs.
		axi_write(`ADDR_CTRL_ONE, 16'h1c03, rs);
		axi_write(`ADDR_CTRL_TWO, 16'h008b, rs);
		axi_write(`ADDR_TIMER, 16'h0000, rs);
		repeat (20) @(posedge clk);
		axi_read(`ADDR_TIMER, rd, rs);
		chk("held", rd[15:0], 0);
		src(5'h0b, 1'b1);
		repeat (4) @(posedge clk);
		src(5'h0b, 1'b0);
		repeat (20) @(posedge clk);
		axi_read(`ADDR_TIMER, rd, rs);
		chk("running", rd[15:0] != 0, 1);
		// Each source code from 0 to 30 in turn; code one is this channel and stays unused.
		// Reserved codes see every source raised at once and must still ignore them.
		for (int c = 0; c <= 30; c++) begin
			if (c == 1) continue;
			sc = (c inside {9, 28, [20:23]}) ? 5'h00 : 5'(c);
			axi_write(`ADDR_CTRL_TWO, 16'h0080 | 16'(c), rs);
			src(sc, 1'b1);
			repeat (4) @(posedge clk);
			src(sc, 1'b0);
			repeat (4) @(posedge clk);
			axi_read(`ADDR_CTRL_TWO, rd, rs);
			chk("trig_stat", rd[6], sc != 5'h00);
		end
		end_of_test();
	end
endmodule : output_compare_channel_tb
`default_nettype wire
